// ### hw/asq_pkg.sv
// Constants and carrier types of the converter sequencer control.
// Assumes one 200 MHz system clock and an AXI4-Lite register port.
package asq_pkg;
    localparam int NSEQ    = 4;
    localparam int RES_W   = 10;
    localparam int NTRIG   = 14;
    localparam int MAX_AVG = 6;                  // 2**6 = 64 samples
    localparam int SEQ_DEPTH [NSEQ] = '{8, 4, 4, 1};
    // Clocking: converter clock target and legal band
    localparam int CLK_HZ   = 200_000_000;
    localparam int CONV_HZ  = 16_667_000;
    localparam int CONV_MIN = 14_000_000;
    localparam int CONV_MAX = 18_000_000;
    // Register byte offsets
    localparam logic [11:0] OFS_ACTSS = 12'h000;
    localparam logic [11:0] OFS_RIS   = 12'h004;
    localparam logic [11:0] OFS_IM    = 12'h008;
    localparam logic [11:0] OFS_ISC   = 12'h00c;
    localparam logic [11:0] OFS_EMUX  = 12'h014;
    localparam logic [11:0] OFS_PRI   = 12'h020;
    localparam logic [11:0] OFS_PSSI  = 12'h028;
    localparam logic [11:0] OFS_SAC   = 12'h030;
    localparam logic [11:0] OFS_TMLB  = 12'h100;
    localparam logic [11:0] SEQ_BASE  = 12'h040;
    localparam logic [11:0] SEQ_STEP  = 12'h020;
    localparam logic [11:0] SEQ_MUX   = 12'h000;
    localparam logic [11:0] SEQ_CTL   = 12'h004;
    localparam logic [11:0] SEQ_RES   = 12'h008;
    // Reset values and field masks
    localparam logic [15:0] PRI_RST   = 16'h3210;
    localparam logic [15:0] PRI_MASK  = 16'h3333;
    localparam logic [31:0] CTL3_RST  = 32'h0000_0002;
    // Step control nibble bits
    localparam int CTL_D   = 0;
    localparam int CTL_END = 1;
    localparam int CTL_IE  = 2;
    localparam int CTL_TS  = 3;
    // Trigger codes
    localparam logic [3:0] TRIG_SW     = 4'h0;
    localparam logic [3:0] TRIG_ALWAYS = 4'hf;
    // Result codes
    localparam logic [RES_W-1:0] DIFF_ZERO = 10'h1ff;
    localparam logic [1:0] RESP_OK  = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;

    typedef enum logic [1:0] {S_IDLE, S_START, S_WAIT} asq_state_t;

    typedef struct packed {
        logic [11:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [11:0] araddr;
        logic        arvalid;
        logic        rready;
    } asq_axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } asq_axil_rsp_t;

    typedef struct packed {
        logic       start;   // One-cycle conversion request
        logic [3:0] chan;    // Input, or even input of a pair
        logic       diff;    // Even minus odd of the pair
        logic       temp;    // Temperature sensor instead of input
    } asq_conv_req_t;
endpackage

// ### hw/asq_ctrl.sv
// Converter sequencer control: registers, triggers, arbitration, averaging.
// Assumes a converter core that answers each request with a done pulse.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module asq_ctrl import asq_pkg::*; #(
    parameter int N_TRIG = NTRIG
) (
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire asq_axil_req_t axi_in,
    output asq_axil_rsp_t      axi_out,
    input  wire logic [N_TRIG-1:0] trig_in,
    output asq_conv_req_t      conv_req_out,
    input  wire logic          conv_done_in,
    input  wire logic [RES_W-1:0] conv_data_in,
    output logic               conv_clk_out,
    output logic [NSEQ-1:0]    irq_out
);
    localparam int DIV  = (CLK_HZ + CONV_HZ / 2) / CONV_HZ;
    localparam int HALF = DIV / 2;

    // Refuse settings the logic cannot serve
    if (N_TRIG < 1 || N_TRIG > NTRIG) begin : g_bad_trig
        $error("N_TRIG out of range");
    end
    if (CLK_HZ / DIV < CONV_MIN || CLK_HZ / DIV > CONV_MAX) begin : g_bad_clk
        $error("Converter clock outside band");
    end

    asq_axil_rsp_t   rsp_r;
    logic [11:0]     aw_addr_r;
    logic [31:0]     w_data_r;
    logic [3:0]      w_strb_r;
    logic            aw_have_r, w_have_r;
    logic            wr_go;
    logic [31:0]     wmask;
    logic [32:0]     rd_w;
    logic [NSEQ-1:0] actss_r, im_r, ris_r, pend_r, irq_r;
    logic [15:0]     emux_r, pri_r;
    logic [2:0]      sac_r;
    logic            tmlb_r;
    logic [31:0]     mux_r [NSEQ];
    logic [31:0]     ctl_r [NSEQ];
    logic [RES_W-1:0] res_r [NSEQ];
    asq_state_t      st_r;
    logic [1:0]      seq_r;
    logic [2:0]      step_r;
    logic [6:0]      avg_cnt_r;
    logic [15:0]     acc_r;
    logic [RES_W-1:0] lb_cnt_r;
    asq_conv_req_t   conv_r;
    logic [3:0]      div_r;
    logic            cclk_r;
    logic [NSEQ-1:0] trig_evt, ready_v, int_set;
    logic            pick_ok;
    logic [1:0]      pick_idx;
    logic [3:0]      nib_in, nib_ctl;
    logic [RES_W-1:0] sample;
    logic            done, res_set, last_step;
    logic [15:0]     acc_sum;

    // Byte lanes from write strobes
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            strb_mask[8*b +: 8] = {8{s[b]}};
        end
    endfunction

    // Register address of one sequencer's register
    function automatic logic [11:0] seq_ofs(input int i, input logic [11:0] sub);
        seq_ofs = SEQ_BASE + 12'(i) * SEQ_STEP + sub;
    endfunction

    // Averaging shift, clamped at 64 samples
    function automatic logic [2:0] avg_sh(input logic [2:0] s);
        avg_sh = (int'(s) > MAX_AVG) ? 3'(MAX_AVG) : s;
    endfunction

    assign wr_go = aw_have_r & w_have_r & ~rsp_r.bvalid;
    assign wmask = strb_mask(w_strb_r);

    // AXI responses: write address and data in either order, read answered a cycle after its address
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_addr_r     <= 12'h000;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            rsp_r.awready <= 1'b1;
            rsp_r.wready  <= 1'b1;
            rsp_r.bvalid  <= 1'b0;
            rsp_r.bresp   <= RESP_OK;
            rsp_r.arready <= 1'b1;
            rsp_r.rvalid  <= 1'b0;
            rsp_r.rdata   <= 32'h0000_0000;
            rsp_r.rresp   <= RESP_OK;
        end else begin
            if (axi_in.awvalid && rsp_r.awready) begin
                aw_addr_r     <= axi_in.awaddr;
                aw_have_r     <= 1'b1;
                rsp_r.awready <= 1'b0;
            end
            if (axi_in.wvalid && rsp_r.wready) begin
                w_data_r     <= axi_in.wdata;
                w_strb_r     <= axi_in.wstrb;
                w_have_r     <= 1'b1;
                rsp_r.wready <= 1'b0;
            end
            if (wr_go) begin
                rsp_r.bvalid <= 1'b1;
                rsp_r.bresp  <= wr_hit(aw_addr_r) ? RESP_OK : RESP_ERR;
            end
            if (rsp_r.bvalid && axi_in.bready) begin
                rsp_r.bvalid  <= 1'b0;
                aw_have_r     <= 1'b0;
                w_have_r      <= 1'b0;
                rsp_r.awready <= 1'b1;
                rsp_r.wready  <= 1'b1;
            end
            if (axi_in.arvalid && rsp_r.arready) begin
                rsp_r.arready <= 1'b0;
                rsp_r.rvalid  <= 1'b1;
                rsp_r.rdata   <= rd_w[31:0];
                rsp_r.rresp   <= rd_w[32] ? RESP_ERR : RESP_OK;
            end else if (rsp_r.rvalid && axi_in.rready) begin
                rsp_r.rvalid  <= 1'b0;
                rsp_r.arready <= 1'b1;
            end
        end
    end

    // Writable addresses
    function automatic logic wr_hit(input logic [11:0] a);
        wr_hit = (a == OFS_ACTSS) || (a == OFS_IM) || (a == OFS_ISC) || (a == OFS_EMUX) ||
                 (a == OFS_PRI) || (a == OFS_PSSI) || (a == OFS_SAC) || (a == OFS_TMLB);
        for (int i = 0; i < NSEQ; i++) begin
            wr_hit = wr_hit || (a == seq_ofs(i, SEQ_MUX)) || (a == seq_ofs(i, SEQ_CTL));
        end
    endfunction

    // Read data mux; results read zero above bit 9
    function automatic logic [32:0] rd_val(input logic [11:0] a);
        rd_val = {1'b1, 32'h0000_0000};
        unique case (a)
            OFS_ACTSS: rd_val = {1'b0, 28'h0, actss_r};
            OFS_RIS:   rd_val = {1'b0, 28'h0, ris_r};
            OFS_IM:    rd_val = {1'b0, 28'h0, im_r};
            OFS_ISC:   rd_val = {1'b0, 28'h0, ris_r & im_r};
            OFS_EMUX:  rd_val = {1'b0, 16'h0, emux_r};
            OFS_PRI:   rd_val = {1'b0, 16'h0, pri_r};
            OFS_SAC:   rd_val = {1'b0, 29'h0, sac_r};
            OFS_TMLB:  rd_val = {1'b0, 31'h0, tmlb_r};
            default: begin
                for (int i = 0; i < NSEQ; i++) begin
                    if (a == seq_ofs(i, SEQ_MUX)) rd_val = {1'b0, mux_r[i]};
                    if (a == seq_ofs(i, SEQ_CTL)) rd_val = {1'b0, ctl_r[i]};
                    if (a == seq_ofs(i, SEQ_RES)) rd_val = {1'b0, 22'h0, res_r[i]};
                end
            end
        endcase
    endfunction

    // Read data for the offered address, latched when the address is taken
    always_comb begin
        rd_w = rd_val(axi_in.araddr);
    end

    // Software configuration registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            actss_r <= '0;
            im_r    <= '0;
            emux_r  <= 16'h0000;
            pri_r   <= PRI_RST;
            sac_r   <= 3'h0;
            tmlb_r  <= 1'b0;
            for (int i = 0; i < NSEQ; i++) begin
                mux_r[i] <= 32'h0000_0000;
                ctl_r[i] <= (i == NSEQ - 1) ? CTL3_RST : 32'h0000_0000;
            end
        end else if (wr_go) begin
            unique case (aw_addr_r)
                OFS_ACTSS: actss_r <= (actss_r & ~wmask[3:0]) | (w_data_r[3:0] & wmask[3:0]);
                OFS_IM:    im_r    <= (im_r & ~wmask[3:0]) | (w_data_r[3:0] & wmask[3:0]);
                OFS_EMUX:  emux_r  <= (emux_r & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0]);
                OFS_PRI:   pri_r   <= ((pri_r & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0])) & PRI_MASK;
                OFS_SAC:   sac_r   <= wmask[0] ? w_data_r[2:0] : sac_r;
                OFS_TMLB:  tmlb_r  <= wmask[0] ? w_data_r[0] : tmlb_r;
                default: begin
                    for (int i = 0; i < NSEQ; i++) begin
                        if (aw_addr_r == seq_ofs(i, SEQ_MUX)) begin
                            mux_r[i] <= (mux_r[i] & ~wmask) | (w_data_r & wmask);
                        end
                        if (aw_addr_r == seq_ofs(i, SEQ_CTL)) begin
                            ctl_r[i] <= (ctl_r[i] & ~wmask) | (w_data_r & wmask);
                        end
                    end
                end
            endcase
        end
    end

    // Trigger decode per sequencer
    for (genvar g = 0; g < NSEQ; g++) begin : g_trig
        logic [3:0] code;
        assign code = emux_r[4*g +: 4];
        always_comb begin
            if (code == TRIG_ALWAYS) begin
                trig_evt[g] = 1'b1;
            end else if (code == TRIG_SW) begin
                trig_evt[g] = wr_go && aw_addr_r == OFS_PSSI && w_data_r[g] && wmask[0];
            end else begin
                trig_evt[g] = (int'(code) <= N_TRIG) ? trig_in[code - 4'h1] : 1'b0;
            end
        end
        assign ready_v[g] = pend_r[g] & actss_r[g];
    end

    // Highest-priority ready sequencer, value 0 wins
    always_comb begin
        pick_ok  = 1'b0;
        pick_idx = 2'd0;
        for (int lvl = NSEQ - 1; lvl >= 0; lvl--) begin
            for (int i = NSEQ - 1; i >= 0; i--) begin
                if (ready_v[i] && int'(pri_r[4*i +: 2]) == lvl) begin
                    pick_ok  = 1'b1;
                    pick_idx = 2'(i);
                end
            end
        end
    end

    // Pending triggers; a new trigger beats the start that consumes one
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pend_r <= '0;
        end else begin
            for (int i = 0; i < NSEQ; i++) begin
                if (!actss_r[i]) begin
                    pend_r[i] <= 1'b0;
                end else if (trig_evt[i]) begin
                    pend_r[i] <= 1'b1;
                end else if (st_r == S_IDLE && pick_ok && pick_idx == 2'(i)) begin
                    pend_r[i] <= 1'b0;
                end
            end
        end
    end

    // Current step fields; pairs use only adjacent even/odd inputs
    assign nib_in    = mux_r[seq_r][4*step_r +: 4];
    assign nib_ctl   = ctl_r[seq_r][4*step_r +: 4];
    assign done      = (st_r == S_WAIT) && (tmlb_r || conv_done_in);
    assign sample    = !tmlb_r ? conv_data_in : (nib_ctl[CTL_D] ? DIFF_ZERO : lb_cnt_r);
    assign acc_sum   = acc_r + 16'(sample);
    assign res_set   = done && avg_cnt_r == 7'((1 << avg_sh(sac_r)) - 1);
    assign last_step = nib_ctl[CTL_END] || int'(step_r) == SEQ_DEPTH[seq_r] - 1;

    // Sequence engine: one sequencer runs to its end step
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r      <= S_IDLE;
            seq_r     <= 2'd0;
            step_r    <= 3'd0;
            avg_cnt_r <= 7'd0;
            acc_r     <= 16'h0000;
            lb_cnt_r  <= '0;
            conv_r    <= '0;
        end else begin
            conv_r.start <= 1'b0;
            unique case (st_r)
                S_IDLE: if (pick_ok) begin
                    seq_r  <= pick_idx;
                    step_r <= 3'd0;
                    st_r   <= S_START;
                end
                S_START: begin
                    conv_r.start <= ~tmlb_r;
                    conv_r.diff  <= nib_ctl[CTL_D];
                    conv_r.temp  <= nib_ctl[CTL_TS];
                    conv_r.chan  <= nib_ctl[CTL_D] ? {1'b0, nib_in[1:0], 1'b0} : nib_in;
                    st_r         <= S_WAIT;
                end
                S_WAIT: if (done) begin
                    lb_cnt_r <= lb_cnt_r + 10'h001;
                    if (res_set) begin
                        avg_cnt_r <= 7'd0;
                        acc_r     <= 16'h0000;
                        step_r    <= step_r + 3'd1;
                        st_r      <= last_step ? S_IDLE : S_START;
                    end else begin
                        avg_cnt_r <= avg_cnt_r + 7'd1;
                        acc_r     <= acc_sum;
                        st_r      <= S_START;
                    end
                end
            endcase
        end
    end

    // Result per step: average, or raw code when averaging is off
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < NSEQ; i++) res_r[i] <= '0;
        end else if (res_set) begin
            res_r[seq_r] <= RES_W'(acc_sum >> avg_sh(sac_r));
        end
    end

    // Raw status: hardware set beats a write-one clear
    for (genvar g = 0; g < NSEQ; g++) begin : g_irq
        assign int_set[g] = res_set && seq_r == 2'(g) && nib_ctl[CTL_IE];
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ris_r <= '0;
            irq_r <= '0;
        end else begin
            ris_r <= int_set | (ris_r & ~((wr_go && aw_addr_r == OFS_ISC && wmask[0]) ?
                     w_data_r[NSEQ-1:0] : '0));
            irq_r <= ris_r & im_r;
        end
    end

    // Converter clock divided from the system clock
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_r  <= 4'h0;
            cclk_r <= 1'b0;
        end else if (int'(div_r) == HALF - 1) begin
            div_r  <= 4'h0;
            cclk_r <= ~cclk_r;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end

    assign axi_out      = rsp_r;
    assign conv_req_out = conv_r;
    assign conv_clk_out = cclk_r;
    assign irq_out      = irq_r;

    // Core requests issued since the last result, counted apart from the averaging counter
    logic [6:0] ncv_r;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ncv_r <= 7'd0;
        end else if (res_set) begin
            ncv_r <= 7'd0;
        end else if (conv_r.start) begin
            ncv_r <= ncv_r + 7'd1;
        end
    end

    a_irq_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        (irq_out & ~$past(im_r)) == '0) else $error("Masked interrupt forwarded");
    a_isc_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_go && aw_addr_r == OFS_ISC && wmask[0] && w_data_r[3] && !int_set[3] |=> !ris_r[3])
        else $error("Status not cleared");
    a_arb_order: assert property (@(posedge clk_in) disable iff (rst_in)
        st_r == S_IDLE && ready_v[0] && pri_r[1:0] == 2'd0 |=> seq_r == 2'd0 && st_r == S_START)
        else $error("Priority 0 not served");
    a_sw_start: assert property (@(posedge clk_in) disable iff (rst_in)
        actss_r[1] && emux_r[7:4] == TRIG_SW && wr_go && aw_addr_r == OFS_PSSI
        && wmask[0] && w_data_r[1] |=> pend_r[1]) else $error("Initiate lost");
    a_avg_count: assert property (@(posedge clk_in) disable iff (rst_in)
        res_set && !tmlb_r |-> 32'(ncv_r) == (1 << avg_sh(sac_r))) else $error("Wrong sample count");
    a_diff_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        res_set && tmlb_r && nib_ctl[CTL_D] && sac_r == 3'd0 ##1 1'b1 |-> res_r[$past(seq_r)] == DIFF_ZERO)
        else $error("Loopback differential code wrong");
    a_off_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        !actss_r[2] |=> !pend_r[2]) else $error("Disabled sequencer pending");
    a_wait_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        st_r == S_WAIT && !done |=> st_r == S_WAIT && $stable(seq_r) && $stable(step_r))
        else $error("Step left early");
    a_start_once: assert property (@(posedge clk_in) disable iff (rst_in)
        conv_req_out.start |=> !conv_req_out.start[*2]) else $error("Start not single");

    c_avg16: cover property (@(posedge clk_in) disable iff (rst_in) res_set && sac_r == 3'd4);
    c_diff:  cover property (@(posedge clk_in) disable iff (rst_in) conv_req_out.start && conv_req_out.diff);
    c_irq:   cover property (@(posedge clk_in) disable iff (rst_in) $rose(irq_out[3]));
endmodule // asq_ctrl

// ### bench/asq_core_model.sv
// Converter core stand-in: answers each start with one done pulse.
// Assumes one request at a time; the delay input sets how slowly it answers.
`timescale 1ns/1ps
module asq_core_model import asq_pkg::*; (
    input  wire logic          clk_in,
    input  wire asq_conv_req_t req_in,
    input  wire logic [3:0]    dly_in,
    output logic               done_out = 1'b0,
    output logic [RES_W-1:0]   data_out = '0
);
    int         wait_n = -1;
    logic [1:0] cnt    = 2'h0;
    // Input k sits at 0x100+0x40k; a pair codes even minus odd around 0x1ff
    always_ff @(posedge clk_in) begin
        done_out <= 1'b0;
        if (req_in.start) begin
            wait_n <= dly_in;
        end else if (wait_n == 0) begin
            done_out <= 1'b1;
            data_out <= (req_in.diff ? 10'h1bf : 10'h100 + 10'h40 * req_in.chan) + cnt;
            cnt      <= cnt + 2'h1;
            wait_n   <= -1;
        end else begin
            wait_n   <= (wait_n > 0) ? wait_n - 1 : -1;
            data_out <= ~data_out;                // Bus no longer held
        end
    end
endmodule // asq_core_model

// ### bench/test_adc_sequencer_module_control.sv
// Self-checking bench of the converter sequencer control.
// Assumes the core model stands on the converter side.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_adc_sequencer_module_control import asq_pkg::*;;
    logic clk_in = 1'b0, rst_in = 1'b1;
    asq_axil_req_t axi = '0;
    asq_axil_rsp_t rsp;
    asq_conv_req_t conv;
    logic [13:0] trig = '0;
    logic [3:0] dly = '0, ch, irq;
    logic done, cclk;
    logic [9:0] data;
    logic [1:0] resp;
    logic [31:0] v, seed = 32'hfea5;
    logic [3:0] chq[$];
    int errors = 0, comparisons = 0, cyc = 0, n, i, j, sac, hc;
    asq_ctrl i_dut (.clk_in, .rst_in, .axi_in(axi), .axi_out(rsp), .trig_in(trig), .conv_req_out(conv),
                    .conv_done_in(done), .conv_data_in(data), .conv_clk_out(cclk), .irq_out(irq));
    asq_core_model i_core (.clk_in, .req_in(conv), .dly_in(dly), .done_out(done), .data_out(data));
    // Clock, start log and run limit
    initial forever #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (conv.start === 1'b1) chq.push_back(conv.chan);
        if (++cyc == 40000) begin errors++; wrap_up(); end
    end
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Bus write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        axi.awaddr <= a; axi.wdata <= d; axi.wstrb <= 4'hf;
        axi.awvalid <= 1'b1; axi.wvalid <= 1'b1; axi.bready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (rsp.awready) axi.awvalid <= 1'b0;
            if (rsp.wready) axi.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        resp = rsp.bresp;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        axi.araddr <= a; axi.arvalid <= 1'b1; axi.rready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (rsp.arready) axi.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        resp = rsp.rresp;
    endtask
    function automatic logic [11:0] sa(input logic [11:0] s, input logic [11:0] o);
        return SEQ_BASE + SEQ_STEP * s + o;
    endfunction
    task automatic nap(input int c);
        repeat (c) @(posedge clk_in);
    endtask
    // Main sequence
    initial begin
        nap(5);
        rst_in <= 1'b0;
        rd(OFS_PRI, v); `CHK(v, 32'h3210)
        rd(OFS_SAC, v); `CHK(v, 32'h0)
        rd(OFS_PSSI, v); `CHK(resp, RESP_ERR)
        wr(OFS_RIS, 32'hf); `CHK(resp, RESP_ERR)
        $display("reset values done");
        // Software start; masking, coding and averaging from a table
        for (i = 0; i < 6; i++) begin
            sac = (i == 2) ? 4 : (i == 3) ? 6 : (i == 4) ? 2 : 0;
            ch = 4'($unsigned($random(seed)) % 3);
            dly <= 4'($random(seed));
            n = chq.size();
            wr(OFS_ACTSS, 32'h0);
            wr(OFS_SAC, sac); wr(sa(3, SEQ_MUX), ch); wr(sa(3, SEQ_CTL), {29'h0, 3'h6 | i[0]});
            wr(OFS_IM, {28'h0, i[1], 3'h0}); wr(OFS_ACTSS, 32'h8); wr(OFS_PSSI, 32'h8);
            for (j = 0; j < 1000 && !v[3]; j++) rd(OFS_RIS, v);
            nap(3);
            `CHK(irq[3], i[1])
            rd(OFS_ISC, v); `CHK(v, {28'h0, i[1], 3'h0})
            `CHK(chq.size() - n, 1 << sac)
            `CHK(chq[n], i[0] ? {1'b0, ch[1:0], 1'b0} : ch)
            rd(sa(3, SEQ_RES), v);
            `CHK(v, {22'h0, (i[0] ? 10'h1bf : 10'h100 + 10'h40 * ch) + (sac ? 10'h1 : 10'(n % 4))})
            wr(OFS_ISC, 32'h0); rd(OFS_RIS, v); `CHK(v, 32'h8)
            wr(OFS_ISC, 32'h8); rd(OFS_RIS, v); `CHK(v, 32'h0)
        end
        $display("software start done");
        // Two sequencers started together follow the priority field
        wr(sa(0, SEQ_CTL), 32'ha); wr(sa(1, SEQ_MUX), 32'h1); wr(sa(1, SEQ_CTL), 32'h2);
        wr(sa(0, SEQ_MUX), 32'h0); wr(OFS_ACTSS, 32'h3);
        for (j = 0; j < 2; j++) begin
            n = chq.size();
            wr(OFS_PRI, j ? 32'h3201 : 32'h3210); wr(OFS_PSSI, 32'h3);
            nap(100);
            `CHK(chq[n], 4'(j))
            `CHK(chq[n + 1], 4'(1 - j))
            `CHK(conv.temp, 1'(j))
        end
        $display("priority done");
        // External trigger ignored while disabled, then taken; always trigger repeats
        wr(OFS_ACTSS, 32'h0); wr(sa(2, SEQ_CTL), 32'h2); wr(OFS_EMUX, 32'h100);
        for (j = 0; j < 2; j++) begin
            n = chq.size();
            trig <= 14'h1;
            nap(1);
            trig <= 14'h0;
            nap(60);
            `CHK(chq.size() - n, j)
            wr(OFS_ACTSS, 32'h4);
        end
        n = chq.size();
        wr(OFS_EMUX, 32'hf00); nap(200); wr(OFS_ACTSS, 32'h0);
        `CHK(chq.size() - n > 3, 1'b1)
        $display("trigger select done");
        // Loopback completes a sequence with no core request
        nap(30);
        n = chq.size();
        wr(OFS_TMLB, 32'h1); wr(OFS_IM, 32'h8); wr(OFS_ACTSS, 32'h8); wr(OFS_PSSI, 32'h8);
        for (j = 0; j < 100 && irq[3] !== 1'b1; j++) nap(1);
        `CHK(irq[3], 1'b1)
        `CHK(chq.size(), n)
        rd(sa(3, SEQ_RES), v); `CHK(v, 32'h1ff)
        hc = 0;
        for (j = 0; j < 24; j++) begin nap(1); hc += cclk; end
        `CHK(hc, 12)
        $display("loopback and clock done");
        wrap_up();
    end
endmodule // test_adc_sequencer_module_control
